// ---- verilog/segment_lcd_driver_control.v ----
// segment display controller: apb registers, banked display memory, scan and drive codes
//
// Notes on behaviour
// - display area 40H-60H scanned continuously
// - display area is its own bank one
// - bank bit zero reaches general memory only
// - bank one indirect 40H-60H hits display
// - direct access always reaches bank zero
// - quarter duty four commons, third three
// - enable ignored in sleep, display off
// - reset high on sleep without idle, disable
// - control holds duty, bias, resistors, enable
// - two bits pick bias resistor value
// - type bit picks waveform A or B
// - logic segment pins follow display memory
// - pins 0-7, 8-15 switch as groups
// - pins 16-23 each selectable
// - scan clock is sub clock over eight
// - duty gives two, three, four slots
// - bias bit picks half or third
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_map.vh"
module segment_lcd_driver_control #(
    parameter SEG_COUNT = `DISP_DEPTH,
    parameter SUB_DIV   = `SUB_DIV
) (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [7:0]             paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output wire                   pready,
    output wire                   pslverr,
    input  wire                   sub_clock,
    output reg  [7:0]             com_drive,
    output reg  [2*SEG_COUNT-1:0] seg_drive,
    output reg  [23:0]            seg_logic_out,
    output reg  [23:0]            seg_logic_en,
    output wire                   display_reset_signal,
    output wire                   display_active,
    output wire                   bias_third_sel,
    output wire [1:0]             bias_resistor_sel,
    output wire                   waveform_type_b
);
    reg  [7:0]  display_control_reg;
    reg  [7:0]  segment_function_select_a;
    reg  [7:0]  segment_function_select_b;
    reg  [7:0]  bank_select_pointer;
    reg  [7:0]  indirect_pointer_two;
    reg  [7:0]  direct_address;
    reg  [7:0]  power_mode;
    reg         read_done;

    wire        display_enable_bit      = display_control_reg[`CTRL_EN];
    wire        display_enable_inverted = ~display_enable_bit;
    wire [1:0]  duty                    = display_control_reg[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
    wire        led_select_bit          = display_control_reg[`CTRL_LED_SELECT_BIT];
    wire [1:0]  mode                    = power_mode[`POWER_MODE_HI:`POWER_MODE_LO];
    wire        idle_mode_enable        = power_mode[`POWER_IDLE_MODE_ENABLE];
    wire        sleeping                = (mode == `MODE_SLEEP);

    // analogue side controls straight from the control register
    assign bias_third_sel    = display_control_reg[`CTRL_BIAS];
    assign bias_resistor_sel = {display_control_reg[`CTRL_RSEL_HI],
                                display_control_reg[`CTRL_RSEL_LO]};
    assign waveform_type_b   = display_control_reg[`CTRL_TYPE];

    assign display_reset_signal = (sleeping & ~idle_mode_enable) | display_enable_inverted;
    assign display_active = display_enable_bit & ~sleeping & ~led_select_bit;

    // ---------------- apb decode ----------------
    wire access   = psel & penable;
    wire is_read  = access & ~pwrite;
    wire is_write = access & pwrite;
    reg  mapped;

    always @* begin
        case (paddr)
            `REG_CTRL, `REG_SEL_A, `REG_SEL_B, `REG_BANK, `REG_PTR,
            `REG_IND_DATA, `REG_DIR_ADDR, `REG_DIR_DATA, `REG_POWER, `REG_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // reads wait one cycle so memory data is registered before it is returned
    assign pready  = pwrite | read_done;
    assign pslverr = access & pready & ~mapped;

    // ---------------- memory routing ----------------
    wire ind_in_disp = (indirect_pointer_two >= `DISP_START) && (indirect_pointer_two <= `DISP_END);
    wire ind_to_disp = bank_select_pointer[0] & ind_in_disp;
    wire ind_to_none = bank_select_pointer[0] & ~ind_in_disp;
    wire ind_sel     = (paddr == `REG_IND_DATA);
    wire dir_sel     = (paddr == `REG_DIR_DATA);

    wire [`GP_AW-1:0]   gp_addr   = dir_sel ? direct_address : indirect_pointer_two;
    wire                gp_we     = is_write & (dir_sel | (ind_sel & ~bank_select_pointer[0]));
    wire [7:0]          disp_off  = indirect_pointer_two - `DISP_START;
    wire [`DISP_AW-1:0] disp_addr = disp_off[`DISP_AW-1:0];
    wire                disp_we   = is_write & ind_sel & ind_to_disp;
    wire [7:0]          gp_q;
    wire [7:0]          disp_q;
    wire [7:0]          scan_q;
    reg  [`DISP_AW-1:0] fetch_addr;

    display_ram #(
        .WIDTH (8),
        .DEPTH (`GP_DEPTH),
        .AW    (`GP_AW)
    ) gp_mem (
        .clk     (clk),
        .rst     (rst),
        .a_we    (gp_we),
        .a_addr  (gp_addr),
        .a_wdata (pwdata[7:0]),
        .a_rdata (gp_q),
        .b_addr  ({`GP_AW{1'b0}}),
        .b_rdata ()
    );

    display_ram #(
        .WIDTH (8),
        .DEPTH (`DISP_DEPTH),
        .AW    (`DISP_AW)
    ) disp_mem (
        .clk     (clk),
        .rst     (rst),
        .a_we    (disp_we),
        .a_addr  (disp_addr),
        .a_wdata (pwdata[7:0]),
        .a_rdata (disp_q),
        .b_addr  (fetch_addr),
        .b_rdata (scan_q)
    );

    // ---------------- scan state ----------------
    reg [2:0] div_count;
    reg       sub_prev;
    reg [1:0] com_index;
    reg       phase;
    reg       frame_pol;
    reg       fetching;
    reg       capture;
    reg [`DISP_AW-1:0] capture_addr;
    reg [SEG_COUNT-1:0] seg_bits;
    reg [23:0] logic_bits;

    wire [1:0] com_count = (duty == `DUTY_HALF) ? 2'd1 :
                           (duty == `DUTY_THIRD) ? 2'd2 : 2'd3;
    wire sub_rise  = sub_clock & ~sub_prev;
    wire scan_tick = sub_rise && (div_count == SUB_DIV - 1);
    wire slot_end  = waveform_type_b | phase;
    wire pol       = waveform_type_b ? frame_pol : ~phase;

    // ---------------- register writes ----------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            display_control_reg       <= `CTRL_RESET;
            segment_function_select_a <= `SEL_A_RESET;
            segment_function_select_b <= `SEL_B_RESET;
            bank_select_pointer       <= `BANK_RESET;
            indirect_pointer_two      <= `PTR_RESET;
            direct_address            <= `PTR_RESET;
            power_mode                <= `POWER_RESET;
        end else if (is_write) begin
            case (paddr)
                `REG_CTRL:     display_control_reg       <= pwdata[7:0];
                `REG_SEL_A:    segment_function_select_a <= {6'h00, pwdata[1:0]};
                `REG_SEL_B:    segment_function_select_b <= pwdata[7:0];
                `REG_BANK:     bank_select_pointer       <= pwdata[7:0];
                `REG_PTR:      indirect_pointer_two      <= pwdata[7:0];
                `REG_DIR_ADDR: direct_address            <= pwdata[7:0];
                `REG_POWER:    power_mode                <= {5'h00, pwdata[2:0]};
                default:       ;
            endcase
        end
    end

    // ---------------- read path ----------------
    reg [7:0] read_value;

    always @* begin
        case (paddr)
            `REG_CTRL:     read_value = display_control_reg;
            `REG_SEL_A:    read_value = segment_function_select_a;
            `REG_SEL_B:    read_value = segment_function_select_b;
            `REG_BANK:     read_value = bank_select_pointer;
            `REG_PTR:      read_value = indirect_pointer_two;
            `REG_IND_DATA: read_value = ind_to_disp ? disp_q : (ind_to_none ? 8'h00 : gp_q);
            `REG_DIR_ADDR: read_value = direct_address;
            `REG_DIR_DATA: read_value = gp_q;
            `REG_POWER:    read_value = power_mode;
            `REG_STATUS:   read_value = {frame_pol, phase, com_index, fetching,
                                         led_select_bit, display_active, display_reset_signal};
            default:       read_value = 8'h00;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata    <= 32'h0000_0000;
            read_done <= 1'b0;
        end else if (is_read && !read_done) begin
            prdata    <= {24'h00_0000, read_value};
            read_done <= 1'b1;
        end else begin
            read_done <= 1'b0;
        end
    end

    // ---------------- divider and slot sequencing ----------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sub_prev  <= 1'b0;
            div_count <= 3'd0;
            com_index <= 2'd0;
            phase     <= 1'b0;
            frame_pol <= 1'b0;
        end else begin
            sub_prev <= sub_clock;
            if (display_reset_signal) begin
                div_count <= 3'd0;
                com_index <= 2'd0;
                phase     <= 1'b0;
                frame_pol <= 1'b0;
            end else if (display_active && sub_rise) begin
                div_count <= (div_count == SUB_DIV - 1) ? 3'd0 : div_count + 3'd1;
                if (scan_tick) begin
                    phase <= waveform_type_b ? 1'b0 : ~phase;
                    if (slot_end) begin
                        if (com_index >= com_count) begin
                            com_index <= 2'd0;
                            frame_pol <= ~frame_pol;
                        end else begin
                            com_index <= com_index + 2'd1;
                        end
                    end
                end
            end
        end
    end

    // ---------------- memory fetch per slot ----------------
    wire start_fetch = scan_tick & display_active & slot_end;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fetching     <= 1'b1;
            fetch_addr   <= {`DISP_AW{1'b0}};
            capture      <= 1'b0;
            capture_addr <= {`DISP_AW{1'b0}};
        end else begin
            capture      <= fetching;
            capture_addr <= fetch_addr;
            if (start_fetch) begin
                fetching   <= 1'b1;
                fetch_addr <= {`DISP_AW{1'b0}};
            end else if (fetching) begin
                if (fetch_addr == SEG_COUNT - 1) begin
                    fetching <= 1'b0;
                end else begin
                    fetch_addr <= fetch_addr + 1'b1;
                end
            end else begin
                // idle sweeps keep logic outputs tracking memory
                fetching   <= 1'b1;
                fetch_addr <= {`DISP_AW{1'b0}};
            end
        end
    end

    // the slot being fetched is the one after a slot end
    reg [1:0] fetch_com;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_com <= 2'd0;
        end else if (display_reset_signal) begin
            // restart in step with the cleared slot counter
            fetch_com <= 2'd0;
        end else if (start_fetch) begin
            fetch_com <= (com_index >= com_count) ? 2'd0 : com_index + 2'd1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < SEG_COUNT; i = i + 1) begin : g_seg
            wire on = seg_bits[i];
            reg  [1:0] level;
            always @* begin
                if (bias_third_sel) begin
                    level = on ? (pol ? `LVL_VSS : `LVL_VA) : (pol ? `LVL_VB : `LVL_VC);
                end else begin
                    level = on ? (pol ? `LVL_VSS : `LVL_VA) : (pol ? `LVL_VA : `LVL_VSS);
                end
            end
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    seg_bits[i]         <= 1'b0;
                    seg_drive[2*i+1:2*i] <= `LVL_VSS;
                end else begin
                    if (capture && capture_addr == i) begin
                        seg_bits[i] <= scan_q[fetch_com];
                    end
                    seg_drive[2*i+1:2*i] <= display_active ? level : `LVL_VSS;
                end
            end
            if (i < 24) begin : g_logic
                wire logic_sel = (i < 8)  ? segment_function_select_a[0] :
                                 (i < 16) ? segment_function_select_a[1] :
                                            segment_function_select_b[i % 8];
                always @(posedge clk or posedge rst) begin
                    if (rst) begin
                        logic_bits[i]    <= 1'b0;
                        seg_logic_out[i] <= 1'b0;
                        seg_logic_en[i]  <= 1'b0;
                    end else begin
                        if (capture && capture_addr == i) begin
                            logic_bits[i] <= scan_q[0];
                        end
                        seg_logic_en[i]  <= logic_sel;
                        seg_logic_out[i] <= logic_sel & logic_bits[i];
                    end
                end
            end
        end
    endgenerate

    // ---------------- common drive ----------------
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_com
            reg [1:0] clevel;
            always @* begin
                if (c > com_count) begin
                    clevel = `LVL_VSS;
                end else if (c == com_index) begin
                    clevel = pol ? `LVL_VA : `LVL_VSS;
                end else if (bias_third_sel) begin
                    clevel = pol ? `LVL_VC : `LVL_VB;
                end else begin
                    clevel = `LVL_VB;
                end
            end
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    com_drive[2*c+1:2*c] <= `LVL_VSS;
                end else begin
                    com_drive[2*c+1:2*c] <= display_active ? clevel : `LVL_VSS;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/lcd_map.vh ----
// register map, field positions and timing constants of the segment display controller
`ifndef LCD_MAP_VH
`define LCD_MAP_VH

`define REG_CTRL        8'h00
`define REG_SEL_A       8'h04
`define REG_SEL_B       8'h08
`define REG_BANK        8'h0C
`define REG_PTR         8'h10
`define REG_IND_DATA    8'h14
`define REG_DIR_ADDR    8'h18
`define REG_DIR_DATA    8'h1C
`define REG_POWER       8'h20
`define REG_STATUS      8'h24

`define CTRL_EN         0
`define CTRL_DUTY_LO    1
`define CTRL_DUTY_HI    2
`define CTRL_BIAS       3
`define CTRL_RSEL_LO    4
`define CTRL_RSEL_HI    5
`define CTRL_TYPE       6
`define CTRL_LED_SELECT_BIT     7
`define CTRL_RESET      8'h00
`define SEL_A_RESET     8'h00
`define SEL_B_RESET     8'h00
`define BANK_RESET      8'h00
`define PTR_RESET       8'h00
`define POWER_RESET     8'h00

`define POWER_MODE_LO   0
`define POWER_MODE_HI   1
`define POWER_IDLE_MODE_ENABLE     2

`define MODE_NORMAL     2'h0
`define MODE_SLOW       2'h1
`define MODE_IDLE       2'h2
`define MODE_SLEEP      2'h3

`define DUTY_HALF       2'h0
`define DUTY_THIRD      2'h1
`define DUTY_QUARTER    2'h2

`define DISP_START      8'h40
`define DISP_END        8'h60
`define DISP_DEPTH      33
`define DISP_AW         6
`define GP_DEPTH        256
`define GP_AW           8

`define SUB_DIV         8

`define LVL_VSS         2'h0
`define LVL_VC          2'h1
`define LVL_VB          2'h2
`define LVL_VA          2'h3

`endif

// ---- verilog/display_ram.v ----
// small byte memory, one read/write port and one read-only scan port, registered reads
`timescale 1ns/1ps
`default_nettype none
module display_ram #(
    parameter WIDTH = 8,
    parameter DEPTH = 33,
    parameter AW    = 6
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             a_we,
    input  wire [AW-1:0]    a_addr,
    input  wire [WIDTH-1:0] a_wdata,
    output reg  [WIDTH-1:0] a_rdata,
    input  wire [AW-1:0]    b_addr,
    output reg  [WIDTH-1:0] b_rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (a_we && (a_addr < DEPTH)) begin
            mem[a_addr] <= a_wdata;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            a_rdata <= {WIDTH{1'b0}};
            b_rdata <= {WIDTH{1'b0}};
        end else begin
            a_rdata <= (a_addr < DEPTH) ? mem[a_addr] : {WIDTH{1'b0}};
            b_rdata <= (b_addr < DEPTH) ? mem[b_addr] : {WIDTH{1'b0}};
        end
    end
endmodule
`default_nettype wire

// ---- tb/lcd_ctrl_sva.sv ----
// concurrent checks on the segment display controller ports
`timescale 1ns/1ps
`default_nettype none
`include "lcd_map.vh"
module lcd_ctrl_sva #(
    parameter SEG_COUNT = 33,
    parameter SUB_DIV   = 8
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic [7:0]             com_drive,
    input wire logic [2*SEG_COUNT-1:0] seg_drive,
    input wire logic [23:0]            seg_logic_en,
    input wire logic                   display_reset_signal,
    input wire logic                   display_active,
    input wire logic                   bias_third_sel,
    input wire logic [1:0]             bias_resistor_sel,
    input wire logic                   waveform_type_b
);
    wire        wr = psel && penable && pwrite && pready;
    logic [7:0] sel_b_seen;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_b_seen <= 8'h00;
        end else if (wr && paddr == `REG_SEL_B) begin
            sel_b_seen <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_BIAS: assert property (wr && paddr == `REG_CTRL |=> bias_third_sel == $past(pwdata[3]))
        else $error("bias select wrong");
    AST_RSEL: assert property (wr && paddr == `REG_CTRL |=> bias_resistor_sel == $past(pwdata[5:4]))
        else $error("resistor select wrong");
    AST_TYPE: assert property (wr && paddr == `REG_CTRL |=> waveform_type_b == $past(pwdata[6]))
        else $error("waveform type wrong");
    AST_EN_OFF: assert property (wr && paddr == `REG_CTRL && !pwdata[0] |=> display_reset_signal)
        else $error("display reset not raised on disable");
    AST_EXCL: assert property (display_reset_signal |-> !display_active)
        else $error("active while in reset");
    AST_IDLE: assert property (!display_active && !$past(display_active) |-> com_drive == 8'h00 && seg_drive == '0)
        else $error("drive while inactive");
    AST_GROUP: assert property (seg_logic_en[7:0] == {8{seg_logic_en[0]}} && seg_logic_en[15:8] == {8{seg_logic_en[8]}})
        else $error("segment group split");
    AST_SELB: assert property (wr && paddr == `REG_SEL_B |-> ##[2:4] seg_logic_en[23:16] == sel_b_seen)
        else $error("single segment select not applied");
endmodule
bind segment_lcd_driver_control lcd_ctrl_sva #(.SEG_COUNT(SEG_COUNT), .SUB_DIV(SUB_DIV)) lcd_ctrl_sva_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .com_drive(com_drive), .seg_drive(seg_drive), .seg_logic_en(seg_logic_en),
    .display_reset_signal(display_reset_signal), .display_active(display_active),
    .bias_third_sel(bias_third_sel), .bias_resistor_sel(bias_resistor_sel), .waveform_type_b(waveform_type_b));
`default_nettype wire

// ---- tb/lcd_panel_model.sv ----
// behavioural glass panel: lit pixels, commons used, scan tick length
`timescale 1ns/1ps
`default_nettype none
`include "lcd_map.vh"
module lcd_panel_model (
    input  wire logic         clk,
    input  wire logic         clear,
    input  wire logic [7:0]   com_drive,
    input  wire logic [65:0]  seg_drive,
    output var  logic [131:0] pix,
    output var  logic [3:0]   com_used,
    output var  int           tick_len
);
    logic [7:0]  last_com;
    logic [65:0] last_seg;
    int          cnt = 0;
    // judged at the end of each tick, once the segment data has settled
    always @(posedge clk) begin
        last_com <= com_drive;
        last_seg <= seg_drive;
        cnt <= cnt + 1;
        if (clear) begin
            pix <= '0;
            com_used <= 4'h0;
            tick_len <= 0;
        end else if (com_drive != last_com) begin
            tick_len <= cnt;
            cnt <= 1;
            for (int n = 0; n < 4; n++) begin
                if (last_com[2*n +: 2] == `LVL_VA) begin
                    com_used[n] <= 1'b1;
                    for (int s = 0; s < 33; s++) begin
                        if (last_seg[2*s +: 2] == `LVL_VSS) begin
                            pix[4*s + n] <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/segment_lcd_driver_control_tb.sv ----
// self-checking bench for the segment display controller
`timescale 1ns/1ps
`default_nettype none
`include "lcd_map.vh"
module segment_lcd_driver_control_tb;
    localparam int SUBP = 10;
    logic         clk, rst, psel, penable, pwrite, sub_clock, pclr, err;
    logic         pready, pslverr, display_reset_signal, display_active, bias_third_sel, waveform_type_b;
    logic [1:0]   bias_resistor_sel;
    logic [3:0]   com_used, m;
    logic [7:0]   paddr, com_drive;
    logic [23:0]  seg_logic_out, seg_logic_en, e, lbits;
    logic [31:0]  pwdata, prdata, rd;
    logic [65:0]  seg_drive;
    logic [131:0] pix;
    int           tick_len, n_errors, total_checks, cyc, seed, i, k, p, d, nc;
    int           gp[256];
    int           disp[33];
    segment_lcd_driver_control segment_lcd_driver_control_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sub_clock(sub_clock), .com_drive(com_drive), .seg_drive(seg_drive),
        .seg_logic_out(seg_logic_out), .seg_logic_en(seg_logic_en), .display_reset_signal(display_reset_signal),
        .display_active(display_active), .bias_third_sel(bias_third_sel),
        .bias_resistor_sel(bias_resistor_sel), .waveform_type_b(waveform_type_b));
    lcd_panel_model lcd_panel_model_inst (.clk(clk), .clear(pclr), .com_drive(com_drive),
        .seg_drive(seg_drive), .pix(pix), .com_used(com_used), .tick_len(tick_len));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // sub oscillator of SUBP cycles and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sub_clock <= (cyc % SUBP) >= SUBP / 2;
        if (cyc == 40000) begin
            n_errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0000_0000);
        check(rd, exp);
    endtask
    task automatic fill();
        wr(`REG_BANK, 1);
        for (k = 0; k < 33; k++) begin
            disp[k] = $random(seed) & 8'hff;
            gp[64 + k] = $random(seed) & 8'hff;
            wr(`REG_PTR, 64 + k);
            wr(`REG_IND_DATA, disp[k]);
            wr(`REG_DIR_ADDR, 64 + k);
            wr(`REG_DIR_DATA, gp[64 + k]);
        end
    endtask
    initial begin
        {rst, psel, penable, pwrite, sub_clock, pclr} = 6'b100000;
        {paddr, pwdata, cyc, n_errors, total_checks} = '0;
        seed = 32'h0000_1e64;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i <= 8'h20; i += 4) begin
            if (i != 8'h14 && i != 8'h1c) rdchk(i, 0);
        end
        wr(8'h28, 32'hffff_ffff);
        rdchk(8'h28, 0);
        check(err, 1);
        fill();
        for (k = 0; k < 33; k++) begin
            wr(`REG_BANK, 1);
            wr(`REG_PTR, 64 + k);
            rdchk(`REG_IND_DATA, disp[k]);
            wr(`REG_BANK, 0);
            rdchk(`REG_IND_DATA, gp[64 + k]);
            wr(`REG_DIR_ADDR, 64 + k);
            wr(`REG_BANK, 1);
            rdchk(`REG_DIR_DATA, gp[64 + k]);
        end
        // pointer just outside the display window in bank one
        for (i = 0; i < 2; i++) begin
            p = i ? 8'h61 : 8'h3f;
            wr(`REG_DIR_ADDR, p);
            wr(`REG_DIR_DATA, 8'h3c);
            wr(`REG_BANK, 1);
            wr(`REG_PTR, p);
            wr(`REG_IND_DATA, 8'hc3);
            rdchk(`REG_IND_DATA, 0);
            wr(`REG_BANK, 0);
            rdchk(`REG_IND_DATA, 8'h3c);
        end
        for (i = 0; i < 8; i++) begin
            d = (i << 3) | ($random(seed) & 32'h0000_0046);
            wr(`REG_CTRL, d);
            @(posedge clk);
            check(bias_third_sel, d[3]);
            check(bias_resistor_sel, d[5:4]);
            check(waveform_type_b, d[6]);
            rdchk(`REG_CTRL, d);
        end
        for (i = 0; i < 32; i++) begin
            wr(`REG_POWER, i >> 2);
            wr(`REG_CTRL, (i & 1) | ((i & 2) << 6));
            @(posedge clk);
            p = ((i >> 2) & 3) == 3;
            check(display_reset_signal, (p && !i[4]) || !i[0]);
            check(display_active, i[0] && !p && !i[1]);
        end
        wr(`REG_POWER, 0);
        for (i = 0; i < 3; i++) begin
            fill();
            pclr <= 1'b1;
            wr(`REG_CTRL, 0);
            // panel stays cleared until the enable has landed
            wr(`REG_CTRL, 1 | (i << 1) | ((i & 1) << 6) | ((i & 1) << 3));
            pclr <= 1'b0;
            nc = i + 2;
            m = (1 << nc) - 1;
            repeat ((2 * nc + 2) * `SUB_DIV * SUBP + 100) @(posedge clk);
            check(com_used, m);
            check(tick_len, `SUB_DIV * SUBP);
            for (k = 0; k < (nc == 4 ? 32 : 33); k++) begin
                check(pix[4*k +: 4] & m, disp[k] & m);
            end
        end
        for (k = 0; k < 24; k++) lbits[k] = disp[k][0];
        for (i = 0; i < 4; i++) begin
            d = $random(seed) & 8'hff;
            wr(`REG_SEL_A, i);
            wr(`REG_SEL_B, d);
            e = {d[7:0], {8{i[1]}}, {8{i[0]}}};
            k = 0;
            while ((seg_logic_out & e) !== (lbits & e) && k < 2000) begin
                @(posedge clk);
                k++;
            end
            repeat (2) @(posedge clk);
            check(seg_logic_en, e);
            check(seg_logic_out & e, lbits & e);
        end
        results();
    end
endmodule
`default_nettype wire
